// File: itfc_classifier.sv
// ----------------------------------------------------------------
// Notes on behaviour
// ----------------------------------------------------------------
// Notes on behaviour
// - pasid request context fetch error gives 9h
// - present extended root half reserved bit gives Ah
// - pasid present extended context reserved gives Bh
// - permitted second-level entry reserved gives qualified Ch
// - execute bit counts only if supported and enabled
// - first-level top entry read error gives 15h
// - lower first-level entry read error gives 17h
// - address type 10b means translated, no pasid
// - translated request, root not present gives 1h
// - translated request, context not present gives 2h
// - translated request, bad context programming gives 3h
// - translated request, root fetch error gives 8h
// - translated request, context fetch error gives 9h
// - translated request, root reserved bit gives Ah
// - translated request, context reserved bit gives Bh
// - wrong translation type gives qualified Dh
// - pasid root fetch error completes with abort
`timescale 1ns/10ps

module itfc_classifier #(
    parameter bit EXEC_SUPPORTED = 1'b1,
    parameter int COUNT_W        = 16
) (
    input  wire logic                        clock,
    input  wire logic                        rst,
    input  wire logic                        clk_en,
    // one walk result per cycle, from the table walker on this clock
    input  wire logic                        req_valid,
    input  wire logic [1:0]                  address_type_field,
    input  wire logic                        req_has_pasid,
    input  wire logic                        extended_mode,
    input  wire logic                        root_fetch_err,
    input  wire logic                        root_present,
    input  wire logic                        lower_half_present,
    input  wire logic                        upper_half_present,
    input  wire logic                        use_upper_half,
    input  wire logic                        root_rsvd_lo,
    input  wire logic                        root_rsvd_hi,
    input  wire logic                        ctx_fetch_err,
    input  wire logic                        ctx_present,
    input  wire logic                        ctx_rsvd,
    input  wire logic                        ctx_aw_unsupported,
    input  wire logic                        ctx_tt_unsupported,
    input  wire logic [2:0]                  ctx_tt,
    input  wire logic                        sl_valid,
    input  wire logic                        sl_read,
    input  wire logic                        sl_write,
    input  wire logic                        sl_exec,
    input  wire logic                        sl_rsvd,
    input  wire logic                        fl_top_err,
    input  wire logic                        fl_lower_err,
    // register port
    input  wire logic [itfc_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]                 reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [31:0]                 reg_rdata,
    // result
    output logic                             res_valid,
    output logic      [7:0]                  res_reason,
    output logic                             res_qualified,
    output logic      [1:0]                  res_status,
    output logic                             res_block,
    output logic                             irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                                res_valid;
        logic [7:0]                          res_reason;
        logic                                res_qualified;
        logic [1:0]                          res_status;
        logic                                res_block;
        logic [itfc_pkg::NUM_EVENTS-1:0]     status;
        logic [itfc_pkg::NUM_EVENTS-1:0]     enable;
        logic                                exec_en;
        logic [7:0]                          last_reason;
        logic [COUNT_W-1:0]                  fault_count;
        logic [31:0]                         rdata;
        logic                                irq;
    } itfc_state_t;

    itfc_state_t st;
    itfc_state_t next_st;

    logic       translated;
    logic       root_half_np;
    logic       root_rsvd_hit;
    logic       tt_blocked;
    logic       exec_eff;
    logic       sl_perm;
    logic       fault;
    logic [7:0] reason;
    logic       qualified;
    logic [itfc_pkg::NUM_EVENTS-1:0] events;
    logic [itfc_pkg::NUM_EVENTS-1:0] clr;

    // ------------------------------------------------------------
    // classification
    // ------------------------------------------------------------
    always_comb begin
        // address type alone decides translated handling; pasid is
        // ignored for such requests
        translated = (address_type_field ==
                      itfc_pkg::ADDR_TYPE_TRANSLATED);
        root_half_np = extended_mode
            ? (use_upper_half ? !upper_half_present
                              : !lower_half_present)
            : !root_present;
        // reserved bits only count in a half that is marked present
        root_rsvd_hit = extended_mode
            ? ((lower_half_present && root_rsvd_lo) ||
               (upper_half_present && root_rsvd_hi))
            : (root_present && root_rsvd_lo);
        tt_blocked = extended_mode
            ? !(ctx_tt == itfc_pkg::EXT_TT_A ||
                ctx_tt == itfc_pkg::EXT_TT_B ||
                ctx_tt == itfc_pkg::EXT_TT_C)
            : (ctx_tt[1:0] != itfc_pkg::LEGACY_TT_ALLOWED);
        exec_eff = EXEC_SUPPORTED && st.exec_en && sl_exec;
        sl_perm  = sl_read || sl_write || exec_eff;
        fault     = 1'b1;
        qualified = 1'b0;
        reason    = itfc_pkg::REASON_NONE;
        // priority chain follows walk order: root, context, paging
        if (root_fetch_err) begin
            reason = itfc_pkg::REASON_ROOT_FETCH;
        end else if (root_half_np) begin
            reason = itfc_pkg::REASON_ROOT_NP;
        end else if (root_rsvd_hit) begin
            reason = itfc_pkg::REASON_ROOT_RSVD;
        end else if (ctx_fetch_err) begin
            reason = itfc_pkg::REASON_CTX_FETCH;
        end else if (!ctx_present) begin
            reason = itfc_pkg::REASON_CTX_NP;
        end else if (ctx_rsvd) begin
            reason = itfc_pkg::REASON_CTX_RSVD;
        end else if (ctx_aw_unsupported || ctx_tt_unsupported) begin
            reason    = itfc_pkg::REASON_CTX_INVALID;
            qualified = 1'b1;
        end else if (tt_blocked) begin
            reason    = itfc_pkg::REASON_CTX_BLOCK;
            qualified = 1'b1;
        end else if (!translated && sl_valid && sl_perm && sl_rsvd) begin
            reason    = itfc_pkg::REASON_SL_RSVD;
            qualified = 1'b1;
        end else if (!translated && req_has_pasid && fl_top_err) begin
            reason    = itfc_pkg::REASON_FL_TOP;
            qualified = 1'b1;
        end else if (!translated && req_has_pasid && fl_lower_err) begin
            reason    = itfc_pkg::REASON_FL_LOWER;
            qualified = 1'b1;
        end else begin
            fault = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        clr     = '0;
        events  = '0;
        next_st.res_valid = req_valid;
        if (req_valid) begin
            next_st.res_reason    = fault ? reason
                                          : itfc_pkg::REASON_NONE;
            next_st.res_qualified = fault && qualified;
            next_st.res_block     = fault;
            if (!fault) begin
                next_st.res_status = itfc_pkg::STATUS_OK;
            end else if (!translated &&
                         reason == itfc_pkg::REASON_ROOT_FETCH) begin
                next_st.res_status = itfc_pkg::STATUS_CA;
            end else begin
                next_st.res_status = itfc_pkg::STATUS_UR;
            end
            if (fault) begin
                next_st.last_reason = reason;
                next_st.fault_count = st.fault_count + 1'b1;
            end
            events[itfc_pkg::STAT_FAULT] = fault;
            events[itfc_pkg::STAT_QUAL]  = fault && qualified;
            events[itfc_pkg::STAT_ABORT] = fault && !translated &&
                (reason == itfc_pkg::REASON_ROOT_FETCH);
        end
        next_st.rdata = '0;
        if (reg_wr) begin
            unique case (reg_addr)
                itfc_pkg::REG_CLEAR: begin
                    clr = reg_wdata[itfc_pkg::NUM_EVENTS-1:0];
                end
                itfc_pkg::REG_ENABLE: begin
                    next_st.enable = reg_wdata[itfc_pkg::NUM_EVENTS-1:0];
                end
                itfc_pkg::REG_CONTROL: begin
                    next_st.exec_en = reg_wdata[itfc_pkg::CTRL_EXEC_EN];
                end
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                itfc_pkg::REG_STATUS: begin
                    next_st.rdata[itfc_pkg::NUM_EVENTS-1:0] = st.status;
                end
                itfc_pkg::REG_ENABLE: begin
                    next_st.rdata[itfc_pkg::NUM_EVENTS-1:0] = st.enable;
                end
                itfc_pkg::REG_LAST_FAULT: begin
                    next_st.rdata[7:0] = st.last_reason;
                end
                itfc_pkg::REG_CONTROL: begin
                    next_st.rdata[itfc_pkg::CTRL_EXEC_EN] = st.exec_en;
                end
                itfc_pkg::REG_FAULT_COUNT: begin
                    next_st.rdata[COUNT_W-1:0] = st.fault_count;
                end
                default: begin
                end
            endcase
        end
        // a new event beats a clear landing in the same cycle
        next_st.status = (st.status & ~clr) | events;
        next_st.irq    = |(next_st.status & next_st.enable);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st        <= '0;
            st.enable <= itfc_pkg::ENABLE_RESET;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign reg_rdata     = st.rdata;
    assign res_valid     = st.res_valid;
    assign res_reason    = st.res_reason;
    assign res_qualified = st.res_qualified;
    assign res_status    = st.res_status;
    assign res_block     = st.res_block;
    assign irq           = st.irq;

endmodule

// File: itfc_classifier_chk.sv
`timescale 1ns/10ps
// ----------------------------------------
// result checker, watches the ports only
// ----------------------------------------
module itfc_classifier_chk (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       clk_en,
    input wire logic       req_valid,
    input wire logic [1:0] address_type_field,
    input wire logic       extended_mode,
    input wire logic       root_fetch_err,
    input wire logic       root_present,
    input wire logic       root_rsvd_lo,
    input wire logic       ctx_fetch_err,
    input wire logic       res_valid,
    input wire logic [7:0] res_reason,
    input wire logic       res_qualified,
    input wire logic [1:0] res_status,
    input wire logic       res_block
);
    logic go;
    logic tr;
    assign go = req_valid & clk_en;
    assign tr = address_type_field == 2'h2;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_answer_next: assert property (go |=> res_valid)
        else $error("no result after request");
    a_no_spurious: assert property (clk_en && !req_valid |=> !res_valid)
        else $error("result without request");
    a_root_fetch_tr: assert property (go && tr && root_fetch_err |=>
        res_reason == 8'h08 && res_status == itfc_pkg::STATUS_UR)
        else $error("root fetch error misreported");
    a_root_absent: assert property (go && tr && !extended_mode &&
        !root_fetch_err && !root_present |=>
        res_reason == 8'h01 && !res_qualified)
        else $error("absent root misreported");
    a_ctx_fetch: assert property (go && tr && !extended_mode &&
        !root_fetch_err && root_present && !root_rsvd_lo && ctx_fetch_err
        |=> res_reason == 8'h09 && !res_qualified)
        else $error("context fetch error misreported");
    a_qual_codes: assert property (res_valid && res_reason inside
        {8'h03, 8'h0c, 8'h0d, 8'h15, 8'h17} |-> res_qualified)
        else $error("qualified code not qualified");
    a_block_fault: assert property (res_valid |->
        res_block == (res_reason != 8'h00))
        else $error("block does not match fault");
    a_abort_cause: assert property (res_valid &&
        res_status == itfc_pkg::STATUS_CA |-> !$past(tr) &&
        res_reason == 8'h08)
        else $error("abort status without its cause");
    a_tr_no_paging: assert property (go && tr |=> !(res_reason inside
        {8'h0c, 8'h15, 8'h17}))
        else $error("paging fault on translated request");
endmodule

bind itfc_classifier itfc_classifier_chk itfc_classifier_chk_i (.*);

// File: itfc_classifier_tb.sv
`timescale 1ns/10ps
module itfc_classifier_tb;
    logic        clock, rst, clk_en, req_valid, req_has_pasid, extended_mode;
    logic        root_fetch_err, root_present, lower_half_present, irq;
    logic        upper_half_present, use_upper_half, root_rsvd_lo, ctx_rsvd;
    logic        root_rsvd_hi, ctx_fetch_err, ctx_present, ctx_aw_unsupported;
    logic        ctx_tt_unsupported, sl_valid, sl_read, sl_write, sl_exec;
    logic        sl_rsvd, fl_top_err, fl_lower_err, reg_wr, reg_rd, res_valid;
    logic        res_qualified, res_block, go, tr, pasid, ext;
    logic [1:0]  address_type_field, res_status;
    logic [2:0]  ctx_tt;
    logic [3:0]  reg_addr;
    logic [7:0]  res_reason;
    logic [11:0] m;
    logic [31:0] reg_wdata, reg_rdata;
    int          num_errors, check_count;

    itfc_walker_model itfc_walker_model_i (.*);
    itfc_classifier itfc_classifier_i (.*);

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic walk(logic t, logic p, logic e, logic [11:0] mk,
                        logic [7:0] rsn, logic q, logic ca);
        logic [1:0] st;
        st = (rsn == 8'h00) ? itfc_pkg::STATUS_OK :
             (ca ? itfc_pkg::STATUS_CA : itfc_pkg::STATUS_UR);
        @(posedge clock);
        {go, tr, pasid, ext, m} <= {1'b1, t, p, e, mk};
        @(posedge clock);
        {go, m} <= 13'h0000;
        #1;
        chk("result", {1'b1, rsn, q, st, |rsn}, {res_valid, res_reason,
            res_qualified, res_status, res_block});
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge clock);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [31:0] e);
        @(posedge clock);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", e, reg_rdata);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd(itfc_pkg::REG_STATUS, 32'h0);
        rd(itfc_pkg::REG_ENABLE, 32'h0);
        wr(4'hf, 32'hffffffff);
        rd(4'hf, 32'h0);
        wr(itfc_pkg::REG_ENABLE, 32'h7);
        walk(1'b0, 1'b1, 1'b1, 12'h001, 8'h08, 1'b0, 1'b1);
        chk("irq", 1, irq);
        rd(itfc_pkg::REG_STATUS, 32'h5);
        rd(itfc_pkg::REG_LAST_FAULT, 32'h8);
        rd(itfc_pkg::REG_FAULT_COUNT, 32'h1);
        wr(itfc_pkg::REG_ENABLE, 32'h0);
        rd(itfc_pkg::REG_ENABLE, 32'h0);
        chk("irq", 0, irq);
        wr(itfc_pkg::REG_ENABLE, 32'h7);
        wr(itfc_pkg::REG_CLEAR, 32'h7);
        rd(itfc_pkg::REG_STATUS, 32'h0);
        chk("irq", 0, irq);
        $display("test registers done");
    endtask
    task automatic t_translated();
        logic [7:0] rs [8] = '{8'h08, 8'h01, 8'h0a, 8'h09,
                               8'h02, 8'h0b, 8'h03, 8'h0d};
        // legacy and extended formats, one broken step at a time
        for (int e = 0; e < 2; e++) begin
            for (int i = 0; i < 8; i++) begin
                walk(1'b1, 1'b0, e[0], 12'h001 << i, rs[i], i > 5,
                     1'b0);
                chk("tr_block", 1, res_block);
                chk("tr_qual", i > 5, res_qualified);
                chk("tr_status", 1, res_status);
            end
        end
        $display("test translated done");
    endtask
    task automatic t_pasid();
        walk(1'b0, 1'b1, 1'b1, 12'h008, 8'h09, 1'b0, 1'b0);
        walk(1'b0, 1'b1, 1'b1, 12'h004, 8'h0a, 1'b0, 1'b0);
        walk(1'b0, 1'b1, 1'b1, 12'h020, 8'h0b, 1'b0, 1'b0);
        walk(1'b0, 1'b1, 1'b1, 12'h100, 8'h0c, 1'b1, 1'b0);
        walk(1'b0, 1'b1, 1'b1, 12'h200, 8'h15, 1'b1, 1'b0);
        walk(1'b0, 1'b1, 1'b1, 12'h400, 8'h17, 1'b1, 1'b0);
        walk(1'b0, 1'b1, 1'b1, 12'h000, 8'h00, 1'b0, 1'b0);
        $display("test pasid done");
    endtask
    task automatic t_priority();
        walk(1'b1, 1'b0, 1'b0, 12'hfff, 8'h08, 1'b0, 1'b0);
        walk(1'b1, 1'b0, 1'b1, 12'h0f0, 8'h02, 1'b0, 1'b0);
        walk(1'b0, 1'b1, 1'b1, 12'h700, 8'h0c, 1'b1, 1'b0);
        walk(1'b1, 1'b0, 1'b0, 12'h700, 8'h00, 1'b0, 1'b0);
        $display("test priority done");
    endtask
    task automatic t_exec();
        wr(itfc_pkg::REG_CONTROL, 32'h0);
        walk(1'b0, 1'b1, 1'b1, 12'h800, 8'h00, 1'b0, 1'b0);
        wr(itfc_pkg::REG_CONTROL, 32'h1);
        rd(itfc_pkg::REG_CONTROL, 32'h1);
        walk(1'b0, 1'b1, 1'b1, 12'h800, 8'h0c, 1'b1, 1'b0);
        $display("test execute done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        // reset asserted and clock enable high, so the block runs
        // as soon as reset drops
        {rst, clk_en, go, tr, pasid, ext, m} = {6'h30, 12'h000};
        {reg_wr, reg_rd, reg_addr, reg_wdata} = 38'h0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_translated();
        t_pasid();
        t_priority();
        t_exec();
        conclude();
    end
    // runs take about a hundred cycles; this leaves wide room
    initial begin
        #100000;
        num_errors++;
        conclude();
    end
endmodule

// File: itfc_pkg.sv
package itfc_pkg;

    // ------------------------------------------------------------
    // fault reason codes
    // ------------------------------------------------------------
    localparam logic [7:0] REASON_NONE        = 8'h00;
    localparam logic [7:0] REASON_ROOT_NP     = 8'h01;
    localparam logic [7:0] REASON_CTX_NP      = 8'h02;
    localparam logic [7:0] REASON_CTX_INVALID = 8'h03;
    localparam logic [7:0] REASON_ROOT_FETCH  = 8'h08;
    localparam logic [7:0] REASON_CTX_FETCH   = 8'h09;
    localparam logic [7:0] REASON_ROOT_RSVD   = 8'h0a;
    localparam logic [7:0] REASON_CTX_RSVD    = 8'h0b;
    localparam logic [7:0] REASON_SL_RSVD     = 8'h0c;
    localparam logic [7:0] REASON_CTX_BLOCK   = 8'h0d;
    localparam logic [7:0] REASON_FL_TOP      = 8'h15;
    localparam logic [7:0] REASON_FL_LOWER    = 8'h17;

    // ------------------------------------------------------------
    // request kinds and header encodings
    // ------------------------------------------------------------
    localparam logic [1:0] ADDR_TYPE_TRANSLATED = 2'h2;
    localparam logic [1:0] LEGACY_TT_ALLOWED    = 2'h1;
    localparam logic [2:0] EXT_TT_A             = 3'h1;
    localparam logic [2:0] EXT_TT_B             = 3'h5;
    localparam logic [2:0] EXT_TT_C             = 3'h7;

    // ------------------------------------------------------------
    // completion status
    // ------------------------------------------------------------
    localparam logic [1:0] STATUS_OK    = 2'h0;
    localparam logic [1:0] STATUS_UR    = 2'h1;
    localparam logic [1:0] STATUS_CA    = 2'h2;

    // ------------------------------------------------------------
    // register map: offsets and layouts
    // ------------------------------------------------------------
    localparam int         ADDR_W          = 4;
    localparam logic [3:0] REG_STATUS      = 4'h0;
    localparam logic [3:0] REG_CLEAR       = 4'h1;
    localparam logic [3:0] REG_ENABLE      = 4'h2;
    localparam logic [3:0] REG_LAST_FAULT  = 4'h3;
    localparam logic [3:0] REG_CONTROL     = 4'h4;
    localparam logic [3:0] REG_FAULT_COUNT = 4'h5;
    localparam int         STAT_FAULT      = 0;
    localparam int         STAT_QUAL       = 1;
    localparam int         STAT_ABORT      = 2;
    localparam int         NUM_EVENTS      = 3;
    localparam int         CTRL_EXEC_EN    = 0;
    localparam logic [NUM_EVENTS-1:0] ENABLE_RESET = 3'h0;

endpackage

// File: itfc_walker_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// requester and table walk outcome model
// ----------------------------------------
module itfc_walker_model (
    input  wire logic        go,
    input  wire logic        tr,
    input  wire logic        pasid,
    input  wire logic        ext,
    input  wire logic [11:0] m,
    output logic             req_valid,
    output logic [1:0]       address_type_field,
    output logic             req_has_pasid,
    output logic             extended_mode,
    output logic             root_fetch_err,
    output logic             root_present,
    output logic             lower_half_present,
    output logic             upper_half_present,
    output logic             use_upper_half,
    output logic             root_rsvd_lo,
    output logic             root_rsvd_hi,
    output logic             ctx_fetch_err,
    output logic             ctx_present,
    output logic             ctx_rsvd,
    output logic             ctx_aw_unsupported,
    output logic             ctx_tt_unsupported,
    output logic [2:0]       ctx_tt,
    output logic             sl_valid,
    output logic             sl_read,
    output logic             sl_write,
    output logic             sl_exec,
    output logic             sl_rsvd,
    output logic             fl_top_err,
    output logic             fl_lower_err
);
    // each mask bit breaks one walk step, so faults can be stacked
    assign req_valid = go;
    assign address_type_field = tr ? 2'h2 : 2'h0;
    assign req_has_pasid = pasid & ~tr;
    assign extended_mode = ext;
    assign root_fetch_err = m[0];
    assign root_present = ~m[1];
    assign lower_half_present = ~m[1];
    assign upper_half_present = ~m[1];
    // extended walks use the upper half to reach its reserved bits
    assign use_upper_half = ext;
    assign root_rsvd_lo = m[2] & ~ext;
    assign root_rsvd_hi = m[2] & ext;
    assign ctx_fetch_err = m[3];
    assign ctx_present = ~m[4];
    assign ctx_rsvd = m[5];
    // legacy walks break the width field, extended ones the type field
    assign ctx_aw_unsupported = m[6] & ~ext;
    assign ctx_tt_unsupported = m[6] & ext;
    assign ctx_tt = m[7] ? 3'h2 : 3'h1;
    assign sl_valid = m[8] | m[11];
    assign sl_read = m[8];
    assign sl_write = 1'b0;
    assign sl_exec = m[11];
    assign sl_rsvd = m[8] | m[11];
    assign fl_top_err = m[9];
    assign fl_lower_err = m[10];
endmodule
